// *** hdl/crc_pkg.sv ***
package crc_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned BANDGAP_MS = 8;
    localparam int unsigned ANALOG_MS = 4;
    localparam int unsigned BANDGAP_CYC = BANDGAP_MS * (CLK_HZ / 1000);
    localparam int unsigned ANALOG_CYC = ANALOG_MS * (CLK_HZ / 1000);
    localparam int unsigned THRESH_MV = 950;
    localparam int unsigned HYST_MV = 850;
    localparam int unsigned PIN_GROUPS = 8;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MSK = 8'h0C;
    localparam logic [7:0] ADDR_PINSEL = 8'h10;
    localparam logic [7:0] ADDR_PERI_RST = 8'h14;
    localparam logic [7:0] ADDR_FLAGS = 8'h18;

    localparam int CTRL_CPU_RST = 0;
    localparam int CTRL_XF = 1;
    localparam int CTRL_DEEP_IDLE = 2;
    localparam int FLG_PWR_LOST = 0;
    localparam int IRQ_REL = 0;
    localparam int IRQ_PWR_LOST = 1;
    localparam int IRQ_W = 2;
    localparam logic [31:0] PERI_RST_RESET = 32'hFFFFFFFF;

    typedef struct packed {
        logic strobe_hi;
        logic clk_lo;
        logic clock_output_pin_run;
        logic sync_lo;
        logic xf_hi;
    } crc_pin_mode_t;

    typedef struct packed {
        logic [PIN_GROUPS-1:0] out;
        logic [PIN_GROUPS-1:0] oe;
    } crc_pins_t;
endpackage : crc_pkg

// *** hdl/crc_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module crc_sync
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic s1_ff;
    logic nxt_s1;
    logic q_ff;
    logic nxt_q;

    always_comb
    begin
        nxt_s1 = d;
        nxt_q = s1_ff;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_ff <= 1'b0;
            q_ff <= 1'b0;
        end
        else
        begin
            s1_ff <= nxt_s1;
            q_ff <= nxt_q;
        end
    end

    assign q = q_ff;
endmodule : crc_sync
`default_nettype wire

// *** hdl/crc_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
// counts while en is high; done once count reached, clears when en falls
module crc_timer #(
    parameter int unsigned CYCLES = 160000
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    output logic done
);
    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;

    always_comb
    begin
        if (!en)
            nxt_cnt = '0;
        else if (cnt_ff != LAST)
            nxt_cnt = cnt_ff + W'(1);
        else
            nxt_cnt = cnt_ff;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_ff <= '0;
        else
            cnt_ff <= nxt_cnt;
    end

    assign done = (cnt_ff == LAST);
endmodule : crc_timer
`default_nettype wire

// *** hdl/chip_reset_combiner.sv ***
// Summary of operation
// RQ1: hardware reset is reset pin AND supply_ok
// RQ2: supply_ok waits 8ms bandgap, 4ms analog, 950mV
// RQ3: regulator disabled forces supply_ok high immediately
// RQ4: reset pin tied high only with regulator on
// RQ5: reset pin low at least three clocks
// RQ6: global reset spares the rtc domain
// RQ7: reset release enables clock generator and boot
// RQ8: rtc power-on reset sets power-lost flag
// RQ9: cpu reset and peripheral resets by software
// RQ10: outside reset pins follow bus pin select
// RQ11: reset drives high, low and z groups
// RQ12: clock_output_pin toggles, sync groups rise, flag rises
// RQ13: deep idle picks reference or rtc clock
// RQ14: reset asserts async, releases through two flops
`timescale 1ns/10ps
`default_nettype none
module chip_reset_combiner #(
    parameter int unsigned BANDGAP_CYCLES = crc_pkg::BANDGAP_CYC,
    parameter int unsigned ANALOG_CYCLES = crc_pkg::ANALOG_CYC
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic rtc_por_n,
    input wire logic rtc_clk,
    input wire logic external_ref_clock,
    input wire logic pll_clock,
    input wire logic clk_sel,
    input wire logic reset_pin_n,
    input wire logic core_regulator_enable_n,
    input wire logic bandgap_active,
    input wire logic analog_supply,
    input wire logic [11:0] core_regulator_output,
    input wire logic [31:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [crc_pkg::PIN_GROUPS-1:0] periph_out_a,
    input wire logic [crc_pkg::PIN_GROUPS-1:0] periph_out_b,
    input wire logic [crc_pkg::PIN_GROUPS-1:0] periph_oe_a,
    input wire logic [crc_pkg::PIN_GROUPS-1:0] periph_oe_b,
    output crc_pkg::crc_pins_t pins,
    output crc_pkg::crc_pin_mode_t pin_mode,
    output logic clock_output_pin,
    output logic general_flag_output,
    output logic memory_clock_enable_pin,
    output logic system_clock,
    output logic hw_reset_n,
    output logic clkgen_enable,
    output logic boot_start,
    output logic cpu_reset_n,
    output logic [31:0] periph_reset_n,
    output logic supply_ok,
    output logic irq
);
    import crc_pkg::*;

    // supply monitor, async in: synchronised first
    logic bg_s;
    logic ana_s;
    logic rst_pin_s;
    logic ldo_dis_s;
    logic bg_done;
    logic ana_done;
    crc_sync u_sync_bg (.clk(pclk), .rst_n(presetn), .d(bandgap_active), .q(bg_s));
    crc_sync u_sync_ana (.clk(pclk), .rst_n(presetn), .d(analog_supply), .q(ana_s));
    crc_sync u_sync_rst (.clk(pclk), .rst_n(presetn), .d(reset_pin_n), .q(rst_pin_s));
    crc_sync u_sync_dis (.clk(pclk), .rst_n(presetn), .d(core_regulator_enable_n),
        .q(ldo_dis_s));
    crc_timer #(.CYCLES(BANDGAP_CYCLES)) u_bg_tmr (.clk(pclk), .rst_n(presetn),
        .en(bg_s), .done(bg_done)); // RQ2
    crc_timer #(.CYCLES(ANALOG_CYCLES)) u_ana_tmr (.clk(pclk), .rst_n(presetn),
        .en(ana_s), .done(ana_done)); // RQ2

    // comparator with hysteresis so good does not chatter near threshold
    logic good_ff;
    logic nxt_good;
    always_comb
    begin
        if (good_ff)
            nxt_good = bg_done && ana_done && (core_regulator_output > 12'(HYST_MV)); // RQ2
        else
            nxt_good = bg_done && ana_done && (core_regulator_output > 12'(THRESH_MV)); // RQ2
    end

    // regulator disabled bypasses the monitor combinationally
    assign supply_ok = core_regulator_enable_n | good_ff; // RQ3

    // combined reset: async assert, two-flop release
    logic comb_rst_n;
    assign comb_rst_n = presetn & reset_pin_n & supply_ok; // RQ1
    logic rel1_ff;
    logic rel2_ff;
    always_ff @(posedge pclk or negedge comb_rst_n)
    begin
        if (!comb_rst_n)
        begin
            rel1_ff <= 1'b0; // RQ14
            rel2_ff <= 1'b0;
        end
        else
        begin
            rel1_ff <= 1'b1;
            rel2_ff <= rel1_ff; // RQ14
        end
    end
    assign hw_reset_n = rel2_ff;
    assign clkgen_enable = rel2_ff; // RQ7

    logic boot_ff;
    logic nxt_boot;
    logic booted_ff;
    logic nxt_booted;
    always_comb
    begin
        nxt_boot = !booted_ff; // RQ7
        nxt_booted = 1'b1;
    end
    always_ff @(posedge pclk or negedge rel2_ff)
    begin
        if (!rel2_ff)
        begin
            boot_ff <= 1'b0;
            booted_ff <= 1'b0;
        end
        else
        begin
            boot_ff <= nxt_boot;
            booted_ff <= nxt_booted;
        end
    end
    assign boot_start = boot_ff;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            good_ff <= 1'b0;
        else
            good_ff <= nxt_good;
    end

    // rtc domain: only its own power-on reset touches it
    logic pwr_lost_rtc_ff;
    logic nxt_pwr_lost_rtc;
    logic pwr_lost_clr_s;
    logic pwr_lost_s;
    logic clr_tgl_ff;
    always_comb
    begin
        nxt_pwr_lost_rtc = pwr_lost_rtc_ff & ~pwr_lost_clr_s;
    end
    always_ff @(posedge rtc_clk or negedge rtc_por_n)
    begin
        if (!rtc_por_n)
            pwr_lost_rtc_ff <= 1'b1; // RQ8 RQ6
        else
            pwr_lost_rtc_ff <= nxt_pwr_lost_rtc;
    end
    crc_sync u_sync_clr (.clk(rtc_clk), .rst_n(rtc_por_n), .d(clr_tgl_ff),
        .q(pwr_lost_clr_s));
    crc_sync u_sync_lost (.clk(pclk), .rst_n(presetn), .d(pwr_lost_rtc_ff),
        .q(pwr_lost_s));

    // registers, reset by the combined global reset
    logic [31:0] ctrl_ff, nxt_ctrl;
    logic [31:0] pinsel_ff, nxt_pinsel;
    logic [31:0] peri_ff, nxt_peri;
    logic [IRQ_W-1:0] ist_ff, nxt_ist;
    logic [IRQ_W-1:0] imsk_ff, nxt_imsk;
    logic nxt_clr_tgl;
    logic lost_d_ff;
    logic [31:0] nxt_prdata;
    logic [31:0] prdata_ff;
    logic err;
    logic wr;
    logic rd;
    logic [IRQ_W-1:0] ev;

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign ev[IRQ_REL] = boot_ff;
    assign ev[IRQ_PWR_LOST] = pwr_lost_s & ~lost_d_ff;

    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        nxt_pinsel = pinsel_ff;
        nxt_peri = peri_ff;
        nxt_imsk = imsk_ff;
        nxt_ist = ist_ff;
        // clear request held until the flag reads back low, so each write clears once
        nxt_clr_tgl = clr_tgl_ff & pwr_lost_s;
        nxt_prdata = 32'h00000000;
        err = 1'b0;
        unique case (paddr[7:0])
            ADDR_CTRL: nxt_prdata = ctrl_ff;
            ADDR_STAT: nxt_prdata = {28'h0000000, supply_ok, boot_ff, ldo_dis_s,
                rst_pin_s};
            ADDR_IRQ_ST: nxt_prdata = {{(32-IRQ_W){1'b0}}, ist_ff};
            ADDR_IRQ_MSK: nxt_prdata = {{(32-IRQ_W){1'b0}}, imsk_ff};
            ADDR_PINSEL: nxt_prdata = pinsel_ff;
            ADDR_PERI_RST: nxt_prdata = peri_ff;
            ADDR_FLAGS: nxt_prdata = {31'h00000000, pwr_lost_s};
            default: err = 1'b1;
        endcase
        if (paddr[31:8] != 24'h000000)
            err = 1'b1;
        if (wr && !err)
        begin
            unique case (paddr[7:0])
                ADDR_CTRL: nxt_ctrl = pwdata; // RQ9
                ADDR_IRQ_ST: nxt_ist = ist_ff & ~pwdata[IRQ_W-1:0];
                ADDR_IRQ_MSK: nxt_imsk = pwdata[IRQ_W-1:0];
                ADDR_PINSEL: nxt_pinsel = pwdata; // RQ10
                ADDR_PERI_RST: nxt_peri = pwdata; // RQ9
                ADDR_FLAGS: if (pwdata[FLG_PWR_LOST]) nxt_clr_tgl = 1'b1; // RQ8
                default: nxt_ctrl = ctrl_ff;
            endcase
        end
        // event set wins over software clear
        nxt_ist = nxt_ist | ev;
        if (!rd || err)
            nxt_prdata = 32'h00000000;
    end

    always_ff @(posedge pclk or negedge rel2_ff)
    begin
        if (!rel2_ff)
        begin
            ctrl_ff <= 32'h00000000; // RQ6
            pinsel_ff <= 32'h00000000;
            // peripherals stay held until software frees them
            peri_ff <= PERI_RST_RESET; // RQ9
            ist_ff <= '0;
            imsk_ff <= '0;
            clr_tgl_ff <= 1'b0;
            lost_d_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end
        else
        begin
            ctrl_ff <= nxt_ctrl;
            pinsel_ff <= nxt_pinsel;
            peri_ff <= nxt_peri;
            ist_ff <= nxt_ist;
            imsk_ff <= nxt_imsk;
            clr_tgl_ff <= nxt_clr_tgl;
            lost_d_ff <= pwr_lost_s;
            prdata_ff <= nxt_prdata;
        end
    end

    // read data registered, so reads take one wait state
    logic rd_wait_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rd_wait_ff <= 1'b0;
        else
            rd_wait_ff <= rd && !rd_wait_ff;
    end
    assign pready = !rd || rd_wait_ff;
    assign pslverr = psel && penable && pready && err;
    assign prdata = prdata_ff;
    assign irq = |(ist_ff & imsk_ff);

    assign cpu_reset_n = rel2_ff & ~ctrl_ff[CTRL_CPU_RST]; // RQ9
    assign periph_reset_n = {32{rel2_ff}} & ~peri_ff; // RQ9

    // clock source: deep idle bypasses the pll
    assign system_clock = ctrl_ff[CTRL_DEEP_IDLE]
        ? (clk_sel ? external_ref_clock : rtc_clk) : pll_clock; // RQ13

    // pin groups during reset
    logic sync_hi_ff;
    always_ff @(posedge pclk or negedge rel2_ff)
    begin
        if (!rel2_ff)
            sync_hi_ff <= 1'b0;
        else
            sync_hi_ff <= 1'b1; // RQ12
    end
    assign pin_mode.strobe_hi = !rel2_ff; // RQ11
    assign pin_mode.clk_lo = !rel2_ff; // RQ11
    assign pin_mode.clock_output_pin_run = 1'b1; // RQ12
    assign pin_mode.sync_lo = !sync_hi_ff; // RQ12
    assign pin_mode.xf_hi = sync_hi_ff; // RQ12
    assign clock_output_pin = pclk; // RQ12
    assign memory_clock_enable_pin = sync_hi_ff; // RQ12
    assign general_flag_output = sync_hi_ff & ~ctrl_ff[CTRL_XF]; // RQ12

    // z group while in reset, else per-pin select between two peripherals
    always_comb
    begin
        for (int i = 0; i < PIN_GROUPS; i++)
        begin
            pins.out[i] = pinsel_ff[i] ? periph_out_b[i] : periph_out_a[i]; // RQ10
            pins.oe[i] = rel2_ff && (pinsel_ff[i] ? periph_oe_b[i] : periph_oe_a[i]); // RQ11
        end
    end
endmodule : chip_reset_combiner
`default_nettype wire

// *** test/crc_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module crc_chk
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic reset_pin_n,
    input wire logic core_regulator_enable_n,
    input wire logic supply_ok,
    input wire logic hw_reset_n,
    input wire logic clkgen_enable,
    input wire logic boot_start,
    input wire logic memory_clock_enable_pin,
    input wire logic general_flag_output,
    input wire crc_pkg::crc_pins_t pins,
    input wire crc_pkg::crc_pin_mode_t pin_mode
);
    import crc_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_pin_and;
        !reset_pin_n |-> !hw_reset_n;
    endproperty
    a_pin_and: assert property (p_pin_and) else $error("reset up, pin low");
    property p_good_and;
        !supply_ok |-> !hw_reset_n;
    endproperty
    a_good_and: assert property (p_good_and) else $error("reset up, supply low");
    property p_reg_off;
        core_regulator_enable_n |-> supply_ok;
    endproperty
    a_reg_off: assert property (p_reg_off) else $error("supply not forced");
    property p_rel_sync;
        $rose(hw_reset_n) |-> $past(reset_pin_n && supply_ok, 2);
    endproperty
    a_rel_sync: assert property (p_rel_sync) else $error("release too early");
    property p_rel_time;
        ($rose(reset_pin_n) && supply_ok) ##1 (reset_pin_n && supply_ok)[*2] |-> hw_reset_n;
    endproperty
    a_rel_time: assert property (p_rel_time) else $error("release too late");
    property p_boot;
        $rose(hw_reset_n) |=> boot_start ##1 !boot_start;
    endproperty
    a_boot: assert property (p_boot) else $error("boot pulse wrong");
    property p_clkgen;
        hw_reset_n[*2] |-> clkgen_enable;
    endproperty
    a_clkgen: assert property (p_clkgen) else $error("clock gen off");
    property p_pin_rst;
        !hw_reset_n |-> pins.oe == '0 && pin_mode.strobe_hi && pin_mode.clk_lo;
    endproperty
    a_pin_rst: assert property (p_pin_rst) else $error("reset pin groups wrong");
    property p_sync_rise;
        $rose(hw_reset_n) |=> memory_clock_enable_pin && general_flag_output && !pin_mode.sync_lo;
    endproperty
    a_sync_rise: assert property (p_sync_rise) else $error("sync group late");
    c_rel: cover property ($rose(hw_reset_n));
    c_drop: cover property ($fell(supply_ok));
    c_off: cover property (core_regulator_enable_n && supply_ok);
endmodule : crc_chk
`default_nettype wire

// *** test/crc_partner.sv ***
`timescale 1ns/10ps
`default_nettype none
module crc_partner
(
    input wire logic pclk,
    input wire logic reg_off,
    input wire logic supplies_up,
    input wire logic [11:0] level_mv,
    input wire logic pulse_req,
    output logic reset_pin_n,
    output logic core_regulator_enable_n,
    output logic bandgap_active,
    output logic analog_supply,
    output logic [11:0] core_regulator_output
);
    logic [1:0] low_cnt_ff = 2'h0;
    logic off_q_ff = 1'b0;
    // pin stays high with the regulator on unless pulse_req asks for a pulse; turning it off brings its own pulse
    assign reset_pin_n = (low_cnt_ff == 2'h0);
    always @(posedge pclk)
    begin
        off_q_ff <= reg_off;
        if (low_cnt_ff != 2'h0)
            low_cnt_ff <= low_cnt_ff - 2'h1;
        else if (pulse_req || (reg_off && !off_q_ff))
            low_cnt_ff <= 2'h3;
    end
    assign core_regulator_enable_n = reg_off;
    assign bandgap_active = supplies_up;
    assign analog_supply = supplies_up;
    assign core_regulator_output = supplies_up ? level_mv : 12'h000;
endmodule : crc_partner
`default_nettype wire

// *** test/chip_reset_combiner_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module chip_reset_combiner_test;
    import crc_pkg::*;
    logic pclk, presetn, rtc_por_n, rtc_clk, ref_clk, pll_clock, clk_sel;
    logic reg_off, sup, preq, rpin_n, reg_en_n, bg, ana;
    logic [11:0] mv, vout;
    logic psel, penable, pwrite, pready, pslverr, e;
    logic [31:0] paddr, pwdata, prdata, q, periph_reset_n;
    logic [7:0] out_a, out_b, oe_a, oe_b;
    crc_pins_t pins;
    logic system_clock, hw_reset_n, cpu_reset_n, supply_ok, irq, xf;
    int bad_count, check_count;
    always #25 pclk = ~pclk;
    always #100 rtc_clk = ~rtc_clk;
    always #40 ref_clk = ~ref_clk;
    always #10 pll_clock = ~pll_clock;
    crc_partner crc_partner_inst (.pclk(pclk), .reg_off(reg_off), .supplies_up(sup),
        .level_mv(mv), .pulse_req(preq), .reset_pin_n(rpin_n), .core_regulator_enable_n(reg_en_n),
        .bandgap_active(bg), .analog_supply(ana), .core_regulator_output(vout));
    chip_reset_combiner #(.BANDGAP_CYCLES(10), .ANALOG_CYCLES(5)) chip_reset_combiner_inst (
        .pclk(pclk), .presetn(presetn), .rtc_por_n(rtc_por_n), .rtc_clk(rtc_clk),
        .external_ref_clock(ref_clk), .pll_clock(pll_clock), .clk_sel(clk_sel),
        .reset_pin_n(rpin_n), .core_regulator_enable_n(reg_en_n), .bandgap_active(bg),
        .analog_supply(ana), .core_regulator_output(vout), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .periph_out_a(out_a), .periph_out_b(out_b), .periph_oe_a(oe_a),
        .periph_oe_b(oe_b), .pins(pins), .pin_mode(), .clock_output_pin(),
        .general_flag_output(xf), .memory_clock_enable_pin(), .system_clock(system_clock),
        .hw_reset_n(hw_reset_n), .clkgen_enable(), .boot_start(), .cpu_reset_n(cpu_reset_n),
        .periph_reset_n(periph_reset_n), .supply_ok(supply_ok), .irq(irq));
    task complete_run;
        $display("checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    // called at a falling edge, where outputs are settled; returns on a rising edge
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
        @(posedge pclk);
    endtask : chk
    task hang;
        bad_count++;
        $display("[FAIL] %0t wait ran out", $time);
        complete_run();
    endtask : hang
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h000000, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        // values read here are those the slave shows at this rising edge
        do
        begin
            @(posedge pclk);
            i++;
        end
        while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1)
            hang();
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask : acc
    task rd(input logic [7:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd
    // sel 0 watches supply_ok, 1 the hardware reset
    task wait_sig(input int sel, input logic lvl, input int lim);
        for (int i = 0; i < lim; i++)
        begin
            @(negedge pclk);
            if ((sel == 1 ? hw_reset_n : supply_ok) === lvl)
            begin
                @(posedge pclk);
                return;
            end
        end
        hang();
    endtask : wait_sig
    initial
    begin
        {pclk, presetn, rtc_por_n, rtc_clk, ref_clk, pll_clock, clk_sel} = 7'h00;
        {reg_off, sup, preq, psel, penable, pwrite} = 6'h00;
        {mv, paddr, pwdata} = '0;
        {out_a, out_b, oe_a, oe_b} = 32'h5AA5FF0F;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rtc_por_n <= 1'b1;
        sup <= 1'b1;
        mv <= 12'h3E8;
        repeat (3) @(negedge pclk);
        chk({31'h0, supply_ok}, 32'h0);
        wait_sig(0, 1'b1, 20);
        mv <= 12'h384;
        repeat (2) @(negedge pclk);
        chk({31'h0, supply_ok}, 32'h1);
        mv <= 12'h320;
        wait_sig(0, 1'b0, 5);
        mv <= 12'h3E8;
        wait_sig(1, 1'b1, 20);
        rd(ADDR_FLAGS, 32'h1);
        acc(1'b1, ADDR_IRQ_MSK, 32'h1);
        chk({31'h0, irq}, 32'h1);
        acc(1'b1, ADDR_IRQ_ST, 32'h1);
        chk({31'h0, irq}, 32'h0);
        rd(ADDR_IRQ_ST, 32'h2);
        rd(ADDR_STAT, 32'h9);
        acc(1'b0, 8'h1C, 32'h0);
        chk({q[30:0], e}, 32'h1);
        rd(ADDR_PERI_RST, PERI_RST_RESET);
        chk(periph_reset_n, 32'h0);
        acc(1'b1, ADDR_PERI_RST, 32'h0);
        chk(periph_reset_n, 32'hFFFFFFFF);
        acc(1'b1, ADDR_CTRL, 32'h1);
        chk({31'h0, cpu_reset_n}, 32'h0);
        acc(1'b1, ADDR_CTRL, 32'h2);
        chk({30'h0, xf, cpu_reset_n}, 32'h1);
        acc(1'b1, ADDR_PINSEL, 32'h0);
        chk({16'h0, pins}, {16'h0, out_a, oe_a});
        acc(1'b1, ADDR_PINSEL, 32'hFF);
        chk({16'h0, pins}, {16'h0, out_b, oe_b});
        acc(1'b1, ADDR_CTRL, 32'h4);
        for (int s = 0; s < 4; s++)
        begin
            @(posedge pclk);
            clk_sel <= s[0];
            @(negedge pclk);
            chk({31'h0, system_clock}, {31'h0, s[0] ? ref_clk : rtc_clk});
        end
        preq <= 1'b1;
        @(posedge pclk);
        preq <= 1'b0;
        wait_sig(1, 1'b0, 5);
        wait_sig(1, 1'b1, 10);
        rd(ADDR_FLAGS, 32'h1);
        rd(ADDR_PINSEL, 32'h0);
        @(negedge pclk);
        chk({31'h0, system_clock}, {31'h0, pll_clock});
        acc(1'b1, ADDR_FLAGS, 32'h1);
        repeat (40) @(posedge pclk);
        rd(ADDR_FLAGS, 32'h0);
        sup <= 1'b0;
        reg_off <= 1'b1;
        repeat (3) @(negedge pclk);
        chk({31'h0, supply_ok}, 32'h1);
        wait_sig(1, 1'b1, 10);
        complete_run();
    end
endmodule : chip_reset_combiner_test
bind chip_reset_combiner crc_chk crc_chk_inst (.pclk(pclk), .presetn(presetn),
    .reset_pin_n(reset_pin_n), .core_regulator_enable_n(core_regulator_enable_n),
    .supply_ok(supply_ok), .hw_reset_n(hw_reset_n), .clkgen_enable(clkgen_enable),
    .boot_start(boot_start), .memory_clock_enable_pin(memory_clock_enable_pin),
    .general_flag_output(general_flag_output), .pins(pins), .pin_mode(pin_mode));
`default_nettype wire
